// ---- design/ready_seq_pkg.sv ----
// Purpose: shared constants and types of the ready/serial output sequencer
// Assumes: one tick of the master clock enable is one converter master clock
// Notes: all phase positions count master clock ticks within one conversion cycle
// Operation
// RQ1: Shift on shift clock fall, host samples rise
// RQ2: 24-bit result, MSB first, during shift phase
// RQ3: Pointer reset at load and pre-ready starts
// RQ4: Held high 4 cycles resets, 20 powers down
// RQ5: 384-tick cycle: 36 ready, 348 shift
// RQ6: Six high ticks after ready low pulse
// RQ7: 24 high ticks end each shift phase
// RQ8: Sync entry: 3-tick low pulse, then high
// RQ9: Sync starts 1537 to 7679 ticks after rise
// RQ10: Restart delay 2042.5 sync, 2318.5 power-down
// RQ11: Power-down no sooner than 7681 ticks
// RQ12: Power-down 6144.5 ticks after last low fall
// RQ13: Channel change holds line high 2043.5 ticks
// RQ14: Isolated host needs only shift clock, line
// RQ15: Channel selects isolated or locally counted
package ready_seq_pkg;
    localparam int unsigned RESULT_W        = 24;
    localparam int unsigned POS_W           = 9;
    localparam int unsigned WAIT_W          = 13;
    localparam int unsigned PTR_W           = 5;
    localparam int unsigned HELD_W          = 5;

    localparam int unsigned MCLK_DIV_DEF    = 5;     // 125 ns master clock at 40 MHz
    localparam logic [POS_W-1:0] CYCLE_LAST = 9'h17f; // 384 ticks per cycle
    localparam logic [POS_W-1:0] POS_PRE    = 9'h000; // 24-tick high before ready
    localparam logic [POS_W-1:0] POS_LOAD   = 9'h012; // last 6 ticks of pre-ready high
    localparam logic [POS_W-1:0] POS_LOW    = 9'h018; // 6-tick low pulse
    localparam logic [POS_W-1:0] POS_GAP    = 9'h01e; // 6-tick high gap
    localparam logic [POS_W-1:0] POS_SHIFT  = 9'h024; // 348-tick shift phase

    localparam logic [HELD_W-1:0] HOLD_SYNC_CYC = 5'h04;
    localparam logic [WAIT_W-1:0] SYNC_PULSE_TICKS = 13'h0003;
    localparam logic [WAIT_W-1:0] SYNC_MIN_TICKS   = 13'h0601; // 1537
    localparam logic [WAIT_W-1:0] SYNC_MAX_TICKS   = 13'h1dff; // 7679
    localparam logic [WAIT_W-1:0] PD_MIN_TICKS     = 13'h1e01; // 7681
    localparam logic [WAIT_W-1:0] PD_DELAY_TICKS   = 13'h1801; // 6144.5 rounded up
    localparam logic [WAIT_W-1:0] SYNC_REC_TICKS   = 13'h07fb; // 2042.5 rounded up
    localparam logic [WAIT_W-1:0] PD_REC_TICKS     = 13'h090f; // 2318.5 rounded up
    localparam logic [WAIT_W-1:0] MUX_REC_TICKS    = 13'h07fc; // 2043.5 rounded up

    typedef enum logic [2:0] {
        ST_RUN        = 3'b000,
        ST_SYNC_PULSE = 3'b001,
        ST_SYNC_HOLD  = 3'b010,
        ST_POWER_DOWN = 3'b011,
        ST_RECOVER    = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic result_ready_phase;
        logic modulator_reset;
        logic power_down;
    } seq_status_t;
endpackage : ready_seq_pkg

// ---- design/ready_shift_sequencer.sv ----
// Purpose: drives the combined ready/serial line through each conversion cycle
// Assumes: shift clock and channel selects are asynchronous pins
// Notes: result word comes from the filter on clk_in, sampled at the end of load
`timescale 1ns/1ps
`default_nettype none
module ready_shift_sequencer #(
    parameter int unsigned MCLK_DIV = ready_seq_pkg::MCLK_DIV_DEF,
    parameter logic [12:0] PD_DELAY = ready_seq_pkg::PD_DELAY_TICKS,
    parameter logic [12:0] SYNC_REC = ready_seq_pkg::SYNC_REC_TICKS,
    parameter logic [12:0] PD_REC   = ready_seq_pkg::PD_REC_TICKS,
    parameter logic [12:0] MUX_REC  = ready_seq_pkg::MUX_REC_TICKS
) (
    input  wire logic                                clk_in,
    input  wire logic                                srst_in,
    input  wire logic                                shift_clock_in,
    input  wire logic                                channel_select_bit0_in,
    input  wire logic                                channel_select_bit1_in,
    input  wire logic [ready_seq_pkg::RESULT_W-1:0]  result_word_in,
    output var  logic                                ready_or_serial_out_line_out,
    output var  ready_seq_pkg::seq_status_t          status_out
);
    import ready_seq_pkg::*;

    if (MCLK_DIV < 1 || MCLK_DIV > 255 || PD_DELAY <= SYNC_PULSE_TICKS ||
        SYNC_REC == 13'h0000 || PD_REC == 13'h0000 || MUX_REC == 13'h0000) begin : g_bad
        $error("ready_shift_sequencer: unsupported parameter value");
    end

    seq_state_t           state_reg;
    logic [7:0]           div_reg;
    logic                 tick;
    logic [2:0]           sclk_sync_reg;
    logic                 sclk_lvl_reg;
    logic                 sclk_prev_reg;
    logic                 sclk_fall;
    logic [1:0]           chs1_reg;
    logic [1:0]           chs2_reg;
    logic [1:0]           chs3_reg;
    logic [1:0]           chan_lvl_reg;
    logic                 chan_change;
    logic [POS_W-1:0]     pos_reg;
    logic [POS_W-1:0]     resume_reg;
    logic [WAIT_W-1:0]    wait_reg;
    logic                 armed_reg;
    logic [HELD_W-1:0]    held_reg;
    logic [PTR_W-1:0]     ptr_reg;
    logic [RESULT_W-1:0]  word_reg;
    logic                 line_next;
    logic                 shift_phase;
    logic                 recover_done;

    // Master clock enable
    assign tick = (div_reg == 8'(MCLK_DIV - 1));
    always_ff @(posedge clk_in) begin
        if (srst_in || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sclk_sync_reg <= 3'h0;
            sclk_lvl_reg  <= 1'b0;
            sclk_prev_reg <= 1'b0;
            chs1_reg      <= 2'h0;
            chs2_reg      <= 2'h0;
            chs3_reg      <= 2'h0;
            chan_lvl_reg  <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], shift_clock_in};
            if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
                sclk_lvl_reg <= sclk_sync_reg[2];
            end
            sclk_prev_reg <= sclk_lvl_reg;
            chs1_reg      <= {channel_select_bit1_in, channel_select_bit0_in};
            chs2_reg      <= chs1_reg;
            chs3_reg      <= chs2_reg;
            if (chs2_reg == chs3_reg) begin
                chan_lvl_reg <= chs3_reg;
            end
        end
    end
    assign sclk_fall   = sclk_prev_reg && !sclk_lvl_reg;
    assign chan_change = (chs2_reg == chs3_reg) && (chs3_reg != chan_lvl_reg);
    assign shift_phase = (state_reg == ST_RUN) && (pos_reg >= POS_SHIFT);
    assign recover_done = (state_reg == ST_RECOVER) && tick && (wait_reg == 13'h0001);

    // Position within the conversion cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pos_reg <= POS_PRE;
        end else if (recover_done) begin
            pos_reg <= resume_reg;
        end else if (state_reg == ST_RUN && tick) begin
            pos_reg <= (pos_reg == CYCLE_LAST) ? POS_PRE : pos_reg + 9'h001; // see RQ5
        end
    end

    // Whole cycles with the shift clock held high; first boundary only arms
    always_ff @(posedge clk_in) begin
        if (srst_in || !sclk_lvl_reg || state_reg != ST_RUN) begin
            armed_reg <= 1'b0;
            held_reg  <= 5'h00;
        end else if (tick && pos_reg == CYCLE_LAST) begin
            armed_reg <= 1'b1;
            if (armed_reg && held_reg != 5'h1f) begin
                held_reg <= held_reg + 5'h01; // see RQ4
            end
        end
    end

    // Mode sequencing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg  <= ST_RUN;
            wait_reg   <= 13'h0000;
            resume_reg <= POS_PRE;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (chan_change) begin
                        state_reg  <= ST_RECOVER; // see RQ13
                        wait_reg   <= MUX_REC;
                        resume_reg <= POS_LOAD;
                    end else if (held_reg == HOLD_SYNC_CYC) begin
                        state_reg <= ST_SYNC_PULSE; // see RQ9
                        wait_reg  <= SYNC_PULSE_TICKS;
                    end
                end
                ST_SYNC_PULSE: begin
                    if (tick && wait_reg == 13'h0001) begin
                        state_reg <= ST_SYNC_HOLD; // see RQ8
                        wait_reg  <= PD_DELAY - SYNC_PULSE_TICKS; // see RQ12
                    end else if (tick) begin
                        wait_reg <= wait_reg - 13'h0001;
                    end
                end
                ST_SYNC_HOLD: begin
                    if (!sclk_lvl_reg) begin
                        state_reg  <= ST_RECOVER; // see RQ10
                        wait_reg   <= SYNC_REC;
                        resume_reg <= POS_PRE;
                    end else if (tick && wait_reg == 13'h0001) begin
                        state_reg <= ST_POWER_DOWN; // see RQ11
                    end else if (tick) begin
                        wait_reg <= wait_reg - 13'h0001;
                    end
                end
                ST_POWER_DOWN: begin
                    if (!sclk_lvl_reg) begin
                        state_reg  <= ST_RECOVER; // see RQ10
                        wait_reg   <= PD_REC;
                        resume_reg <= POS_PRE;
                    end
                end
                ST_RECOVER: begin
                    if (recover_done) begin
                        state_reg <= ST_RUN;
                    end else if (tick) begin
                        wait_reg <= wait_reg - 13'h0001;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // Output bit pointer and result holding register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ptr_reg  <= 5'h00;
            word_reg <= '0;
        end else begin
            if (state_reg == ST_RUN && tick && (pos_reg == POS_PRE || pos_reg == POS_LOAD)) begin
                ptr_reg <= 5'h00; // see RQ3
            end else if (shift_phase && sclk_fall && ptr_reg != 5'(RESULT_W)) begin
                ptr_reg <= ptr_reg + 5'h01; // see RQ1
            end
            if (state_reg == ST_RUN && tick && pos_reg == POS_LOW - 9'h001) begin
                word_reg <= result_word_in;
            end
        end
    end

    always_comb begin
        line_next = 1'b1;
        case (state_reg)
            ST_RUN: begin
                if (pos_reg >= POS_LOW && pos_reg < POS_GAP) begin
                    line_next = 1'b0; // see RQ5
                end else if (shift_phase) begin
                    // Past the last bit the line idles low
                    line_next = (ptr_reg < 5'(RESULT_W)) ?
                                word_reg[5'(RESULT_W - 1) - ptr_reg] : 1'b0; // see RQ2
                end
            end
            ST_SYNC_PULSE: line_next = 1'b0; // see RQ8
            default:       line_next = 1'b1;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ready_or_serial_out_line_out <= 1'b1;
            status_out                   <= '0;
        end else begin
            ready_or_serial_out_line_out      <= line_next;
            status_out.result_ready_phase     <= (state_reg == ST_RUN) && (pos_reg < POS_SHIFT);
            status_out.modulator_reset        <= (state_reg != ST_RUN) && (state_reg != ST_RECOVER); // see RQ4
            status_out.power_down             <= (state_reg == ST_POWER_DOWN);
        end
    end

    // Checking helper: ticks since the shift clock rose, saturating
    logic [WAIT_W-1:0] hi_ticks_reg;
    always_ff @(posedge clk_in) begin
        if (srst_in || !sclk_lvl_reg) begin
            hi_ticks_reg <= 13'h0000;
        end else if (tick && hi_ticks_reg != 13'h1fff) begin
            hi_ticks_reg <= hi_ticks_reg + 13'h0001;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_enter_sync;
        state_reg == ST_RUN && held_reg == HOLD_SYNC_CYC && !chan_change;
    endsequence
    sequence s_pulse_then_hold;
        ##1 state_reg == ST_SYNC_PULSE ##1 !ready_or_serial_out_line_out;
    endsequence

    AST_LOW_PULSE: assert property (state_reg == ST_RUN && pos_reg >= POS_LOW &&
        pos_reg < POS_GAP |=> !ready_or_serial_out_line_out) else $error("ready low missing"); // see RQ5
    AST_GAP_HIGH: assert property (state_reg == ST_RUN && pos_reg >= POS_GAP &&
        pos_reg < POS_SHIFT |=> ready_or_serial_out_line_out) else $error("gap not high"); // see RQ6
    AST_PRE_HIGH: assert property (state_reg == ST_RUN && pos_reg < POS_LOW
        |=> ready_or_serial_out_line_out) else $error("pre-ready not high"); // see RQ7
    AST_PTR_RESET: assert property (state_reg == ST_RUN && tick && pos_reg == POS_LOAD
        |=> ptr_reg == 5'h00) else $error("pointer not reset"); // see RQ3
    AST_MSB_FIRST: assert property (shift_phase && ptr_reg == 5'h00
        |=> ready_or_serial_out_line_out == word_reg[RESULT_W-1]) else $error("msb not first"); // see RQ2
    AST_SHIFT_FALL: assert property (shift_phase && sclk_fall && ptr_reg < 5'h17
        |=> ptr_reg == $past(ptr_reg) + 5'h01) else $error("no advance on fall"); // see RQ1
    AST_SYNC_PULSE: assert property (s_enter_sync |-> s_pulse_then_hold)
        else $error("sync pulse missing"); // see RQ8
    AST_SYNC_WINDOW: assert property ($rose(state_reg == ST_SYNC_PULSE) |->
        hi_ticks_reg >= SYNC_MIN_TICKS && hi_ticks_reg <= SYNC_MAX_TICKS)
        else $error("sync start out of window"); // see RQ9
    AST_PD_MIN: assert property ($rose(status_out.power_down) |->
        hi_ticks_reg >= PD_MIN_TICKS - 13'h0002) else $error("power-down too early"); // see RQ11
    AST_HOLD_RESET: assert property (state_reg == ST_SYNC_HOLD || state_reg == ST_POWER_DOWN
        |=> status_out.modulator_reset && ready_or_serial_out_line_out)
        else $error("hold state not reset"); // see RQ4
    AST_RECOVER_HIGH: assert property (state_reg == ST_RECOVER
        |=> ready_or_serial_out_line_out) else $error("recovery line low"); // see RQ13
endmodule : ready_shift_sequencer
`default_nettype wire

// ---- test/host_reader.sv ----
// Purpose: host model that drives the shift clock and reads the line
// Assumes: the line settles within six clk_in cycles of a shift clock fall
// Notes: the low half is longer than the high half to cover the sync latency
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    input  wire logic        clk_in,
    input  wire logic        line_in,
    output var  logic        sclk_out,
    output var  logic [23:0] word_out,
    output var  logic        word_valid_out
);
    initial begin
        sclk_out       = 1'b0;
        word_out       = 24'h000000;
        word_valid_out = 1'b0;
    end
    // Only the shift clock and the line cross the barrier
    task automatic read_word(input int nb);
        word_out = 24'h000000;
        @(posedge clk_in);
        #1;
        for (int i = 0; i < nb; i++) begin
            sclk_out = 1'b1;
            word_out = {word_out[22:0], line_in};
            // Short high half: next bit appears six clk_in edges after the fall
            #50 sclk_out = 1'b0;
            #150;
        end
        word_valid_out = 1'b1;
        @(posedge clk_in);
        #1 word_valid_out = 1'b0;
    endtask : read_word
    // Held high only when commanded
    task automatic drive_level(input logic lvl);
        @(posedge clk_in);
        #1 sclk_out = lvl;
    endtask : drive_level
endmodule : host_reader
`default_nettype wire

// ---- test/adc_ready_shift_sequencer_tb.sv ----
// Purpose: self-checking bench of the ready/serial line sequencer
// Assumes: one master tick per clk_in cycle
// Notes: recoveries shortened, power-down delay kept at its default
`timescale 1ns/1ps
`default_nettype none
module adc_ready_shift_sequencer_tb;
    import ready_seq_pkg::*;
    localparam logic [12:0] REC = 13'h00a;
    logic        clk_in      = 1'b0;
    logic        srst_in     = 1'b1;
    logic [1:0]  chan        = 2'b00;
    logic [23:0] result_word = 24'h5a3c96;
    logic        line;
    logic        sclk;
    logic [23:0] word;
    logic        word_valid;
    seq_status_t status;
    logic [23:0] exp_q[$];
    logic [31:0] rnd         = 32'h0000004f;
    logic [31:0] n;
    int          errors      = 0;
    int          compares    = 0;
    time         t0;
    time         t1;
    always #12.5 clk_in = ~clk_in;
    ready_shift_sequencer #(.MCLK_DIV(1), .SYNC_REC(REC), .PD_REC(REC), .MUX_REC(REC))
        u_ready_shift_sequencer (.clk_in(clk_in), .srst_in(srst_in), .shift_clock_in(sclk),
        .channel_select_bit0_in(chan[0]), .channel_select_bit1_in(chan[1]),
        .result_word_in(result_word), .ready_or_serial_out_line_out(line),
        .status_out(status));
    host_reader u_host_reader (.clk_in(clk_in), .line_in(line), .sclk_out(sclk),
        .word_out(word), .word_valid_out(word_valid));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask : tick
    task automatic wait_level(input logic lvl);
        for (int i = 0; line !== lvl; i++) begin
            if (i > 9000) begin
                errors++;
                summarize();
            end
            tick();
        end
    endtask : wait_level
    // Length of the current run of lvl, started just after its edge
    task automatic run_len(input logic lvl, output logic [31:0] len);
        len = 0;
        while (line === lvl) begin
            if (len >= 9000) begin
                errors++;
                summarize();
            end
            tick();
            len++;
        end
    endtask : run_len
    // MSB forced high beforehand so only ready and sync pulses go low
    task automatic hold_sync();
        u_host_reader.drive_level(1'b1);
        t0 = $time;
        do begin
            wait_level(1'b0);
            t1 = $time;
            run_len(1'b0, n);
        end while (status.modulator_reset !== 1'b1 && $time - t0 < 250000);
        if (status.modulator_reset !== 1'b1) begin
            errors++;
            summarize();
        end
        check("sync_low", n, 32'h00000003);
        check("sync_win", (t1 - t0) / 25 >= 1537 && (t1 - t0) / 25 <= 7679, 1'b1);
    endtask : hold_sync
    task automatic release_check(input string what);
        u_host_reader.drive_level(1'b0);
        t0 = $time;
        wait_level(1'b0);
        check(what, ($time - t0) / 25 >= REC + 24 && ($time - t0) / 25 <= REC + 32, 1'b1);
        check("mod_reset", {status.modulator_reset, status.power_down}, 2'b00);
        run_len(1'b0, n);
    endtask : release_check
    always @(posedge clk_in) begin
        if (word_valid === 1'b1) begin
            check("word", {8'h00, word}, {8'h00, exp_q.pop_front()});
        end
    end
    initial begin
        #2500000;
        errors++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        #1 srst_in = 1'b0;
        for (int k = 0; k < 4; k++) begin
            wait_level(1'b0);
            run_len(1'b0, n);
            check("ready_low", n, 32'h00000006);
            check("ready_phase", status.result_ready_phase, 1'b1);
            if (result_word[23] === 1'b0) begin
                run_len(1'b1, n);
                check("gap_high", n, 32'h00000006);
            end else begin
                repeat (6) tick();
            end
            exp_q.push_back(k == 3 ? result_word >> 14 : result_word);
            rnd = xs(rnd);
            result_word = rnd[23:0];
            u_host_reader.read_word(k == 3 ? 10 : 24);
            check("shift_phase", status.result_ready_phase, 1'b0);
            if (k < 3) begin
                wait_level(1'b1);
                run_len(1'b1, n);
                check("pre_ready", n, 32'h00000018);
            end
            $display("test read %0d done", k);
        end
        result_word[23] = 1'b1;
        hold_sync();
        repeat (50) tick();
        release_check("sync_restart");
        $display("test sync done");
        hold_sync();
        for (n = 0; status.power_down !== 1'b1 && n < 7000; n++) begin
            check("pd_line", line, 1'b1);
            tick();
        end
        if (status.power_down !== 1'b1) begin
            errors++;
            summarize();
        end
        check("pd_min", ($time - t0) / 25 >= 7681, 1'b1);
        check("pd_delay", ($time - t1) / 25 >= 6143 && ($time - t1) / 25 <= 6147, 1'b1);
        release_check("pd_restart");
        $display("test power down done");
        for (int c = 1; c <= 4; c++) begin
            repeat (34) tick();
            chan = c[1:0];
            t0 = $time;
            repeat (6) tick();
            wait_level(1'b1);
            run_len(1'b1, n);
            check("mux_hold", ($time - t0) / 25 >= REC + 6 && ($time - t0) / 25 <= REC + 12, 1'b1);
            run_len(1'b0, n);
            check("mux_low", n, 32'h00000006);
        end
        $display("test channel done");
        summarize();
    end
endmodule : adc_ready_shift_sequencer_tb
`default_nettype wire
